// >>> fault_a_pkg.sv
package fault_a_pkg;

   // ***************
   // register map
   // ***************
   localparam logic [11:0] FAULT_A_CONTROL_OFFS = 12'h000;
   localparam logic [11:0] KEY_OFFS = 12'h004;
   localparam logic [11:0] STATUS_OFFS = 12'h008;
   localparam logic [11:0] PERIOD_OFFS = 12'h00C;

   // ***************
   // field layout of fault_a_control
   // ***************
   localparam int ENABLE_LSB = 0;
   localparam int MODE_BIT = 7;
   localparam int OVERRIDE_LSB = 8;
   localparam logic [15:0] CONTROL_WRITE_MASK = 16'h3F87;

   // ***************
   // reset values and unlock keys
   // ***************
   localparam logic [2:0] ENABLE_RESET_LOCKED = 3'h7;
   localparam logic [2:0] ENABLE_RESET_OPEN = 3'h0;
   localparam logic [15:0] KEY_FIRST = 16'hABCD;
   localparam logic [15:0] KEY_SECOND = 16'h4321;
   localparam logic [15:0] PERIOD_RESET = 16'h0063;
   localparam int STRAP_SYNC_CYCLES = 2;

   typedef struct packed {
      logic [5:0] override_level;
      logic cycle_mode;
      logic [2:0] pair_enable;
   } fault_cfg_t;

   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
   } pin_pairs_t;

   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_HALF = 2'b01,
      KEY_OPEN = 2'b10
   } key_state_t;

endpackage

// >>> bit_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb
   begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

// >>> period_tick.sv
`timescale 1ns/1ps
`default_nettype none
module period_tick (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] period,
   output logic tick
);
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic tick_q;
   logic tick_d;

   // stand-in for the time base: one pulse per period boundary
   always_comb
   begin
      tick_d = (count_q >= period);
      count_d = tick_d ? 16'h0000 : count_q + 16'h0001;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule
`default_nettype wire

// >>> fault_a_override.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fault_a_override (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic FAULT_A_N,
   input wire logic WRITE_LOCK_CONFIG,
   input wire logic [2:0] PWM_HIGH_IN,
   input wire logic [2:0] PWM_LOW_IN,
   output logic [2:0] PAIR_HIGH_OUTPUT,
   output logic [2:0] PAIR_LOW_OUTPUT
);

   // ***************
   // synchronisers and period source
   // ***************
   logic fault_n_s;
   logic lock_s;
   logic period_tick_w;
   logic fault_active;

   bit_sync #(.WIDTH(1)) u_fault_sync (
      .clk(CLK),
      .rstn(RSTN),
      .async_in(FAULT_A_N),
      .sync_out(fault_n_s)
   );

   bit_sync #(.WIDTH(1)) u_lock_sync (
      .clk(CLK),
      .rstn(RSTN),
      .async_in(WRITE_LOCK_CONFIG),
      .sync_out(lock_s)
   );

   assign fault_active = ~fault_n_s;

   // ***************
   // state
   // ***************
   fault_a_pkg::fault_cfg_t cfg_q;
   fault_a_pkg::fault_cfg_t cfg_d;
   fault_a_pkg::key_state_t key_q;
   fault_a_pkg::key_state_t key_d;
   logic [15:0] period_q;
   logic [15:0] period_d;
   logic [1:0] strap_cnt_q;
   logic [1:0] strap_cnt_d;
   logic latched_q;
   logic latched_d;
   logic cbc_q;
   logic cbc_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   fault_a_pkg::pin_pairs_t pins_q;
   fault_a_pkg::pin_pairs_t pins_d;

   period_tick u_period (
      .clk(CLK),
      .rstn(RSTN),
      .period(period_q),
      .tick(period_tick_w)
   );

   logic setup;
   logic wr_access;
   logic hit_ctrl;
   logic hit_key;
   logic hit_stat;
   logic hit_per;
   logic ctrl_write_ok;
   logic forcing;
   logic [15:0] ctrl_view;

   assign setup = PSEL & ~PENABLE;
   assign wr_access = setup & PWRITE;
   assign hit_ctrl = (PADDR == fault_a_pkg::FAULT_A_CONTROL_OFFS);
   assign hit_key = (PADDR == fault_a_pkg::KEY_OFFS);
   assign hit_stat = (PADDR == fault_a_pkg::STATUS_OFFS);
   assign hit_per = (PADDR == fault_a_pkg::PERIOD_OFFS);
   // locked register opens only after the two keys, for one write
   assign ctrl_write_ok = ~lock_s | (key_q == fault_a_pkg::KEY_OPEN);
   assign forcing = latched_q | cbc_q;
   // unimplemented bits come back as zero
   assign ctrl_view = {2'b00, cfg_q.override_level, cfg_q.cycle_mode, 4'h0,
      cfg_q.pair_enable};

   // ***************
   // registers and key sequence
   // ***************
   always_comb
   begin
      cfg_d = cfg_q;
      key_d = key_q;
      period_d = period_q;
      strap_cnt_d = strap_cnt_q;
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      // load one cycle past the sync depth: before that lock_s still shows reset 0
      if (strap_cnt_q <= 2'(fault_a_pkg::STRAP_SYNC_CYCLES))
      begin
         strap_cnt_d = strap_cnt_q + 2'h1;
         if (strap_cnt_q == 2'(fault_a_pkg::STRAP_SYNC_CYCLES))
         begin
            cfg_d.pair_enable = lock_s ? fault_a_pkg::ENABLE_RESET_LOCKED
               : fault_a_pkg::ENABLE_RESET_OPEN;
         end
      end
      if (setup)
      begin
         // one-wait answer: taken in setup, ready in access
         pready_d = 1'b1;
         pslverr_d = ~(hit_ctrl | hit_key | hit_stat | hit_per);
         prdata_d = 32'h0000_0000;
         if (hit_ctrl)
         begin
            prdata_d = {16'h0000, ctrl_view};
         end
         else if (hit_stat)
         begin
            prdata_d = {26'h0, lock_s, key_q == fault_a_pkg::KEY_OPEN,
               fault_active, cbc_q, latched_q, forcing};
         end
         else if (hit_per)
         begin
            prdata_d = {16'h0000, period_q};
         end
      end
      if (wr_access & hit_key)
      begin
         unique case (key_q)
            fault_a_pkg::KEY_IDLE:
               key_d = (PWDATA[15:0] == fault_a_pkg::KEY_FIRST) ? fault_a_pkg::KEY_HALF
                  : fault_a_pkg::KEY_IDLE;
            fault_a_pkg::KEY_HALF:
               key_d = (PWDATA[15:0] == fault_a_pkg::KEY_SECOND) ? fault_a_pkg::KEY_OPEN
                  : fault_a_pkg::KEY_IDLE;
            fault_a_pkg::KEY_OPEN:
               key_d = fault_a_pkg::KEY_OPEN;
            default:
               key_d = fault_a_pkg::KEY_IDLE;
         endcase
      end
      else if (wr_access & hit_ctrl)
      begin
         // any control write spends the unlock
         key_d = fault_a_pkg::KEY_IDLE;
         if (ctrl_write_ok)
         begin
            cfg_d.override_level = PWDATA[13:8];
            cfg_d.cycle_mode = PWDATA[fault_a_pkg::MODE_BIT];
            cfg_d.pair_enable = PWDATA[2:0];
         end
      end
      else if (wr_access & hit_per)
      begin
         period_d = PWDATA[15:0];
      end
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         cfg_q <= '0;
         key_q <= fault_a_pkg::KEY_IDLE;
         period_q <= fault_a_pkg::PERIOD_RESET;
         strap_cnt_q <= 2'h0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         cfg_q <= cfg_d;
         key_q <= key_d;
         period_q <= period_d;
         strap_cnt_q <= strap_cnt_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ***************
   // fault response and pins
   // ***************
   always_comb
   begin
      latched_d = latched_q;
      cbc_d = cbc_q;
      if (cfg_q.cycle_mode)
      begin
         latched_d = 1'b0;
         // hold while active, drop at next period boundary
         if (fault_active)
         begin
            cbc_d = 1'b1;
         end
         else if (period_tick_w)
         begin
            cbc_d = 1'b0;
         end
      end
      else
      begin
         cbc_d = 1'b0;
         // latch stays until software selects cycle mode
         if (fault_active)
         begin
            latched_d = 1'b1;
         end
      end
      for (int i = 0; i < 3; i++)
      begin
         if (forcing & cfg_q.pair_enable[i])
         begin
            pins_d.high[i] = cfg_q.override_level[2 * i + 1];
            pins_d.low[i] = cfg_q.override_level[2 * i];
         end
         else
         begin
            pins_d.high[i] = PWM_HIGH_IN[i];
            pins_d.low[i] = PWM_LOW_IN[i];
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         latched_q <= 1'b0;
         cbc_q <= 1'b0;
         pins_q <= '0;
      end
      else
      begin
         latched_q <= latched_d;
         cbc_q <= cbc_d;
         pins_q <= pins_d;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign PAIR_HIGH_OUTPUT = pins_q.high;
   assign PAIR_LOW_OUTPUT = pins_q.low;

   // ***************
   // assertions
   // ***************
   property p_pair_forced;
      @(posedge CLK) disable iff (!RSTN)
      (forcing && cfg_q.pair_enable[0]) |=> (PAIR_HIGH_OUTPUT[0] == $past(cfg_q.override_level[1]));
   endproperty
   a_pair_forced: assert property (p_pair_forced) else $error("pair one not forced");

   property p_pair2_free;
      @(posedge CLK) disable iff (!RSTN)
      (!cfg_q.pair_enable[1]) |=> (PAIR_LOW_OUTPUT[1] == $past(PWM_LOW_IN[1]));
   endproperty
   a_pair2_free: assert property (p_pair2_free) else $error("pair two disturbed");

   property p_pair3_forced;
      @(posedge CLK) disable iff (!RSTN)
      (forcing && cfg_q.pair_enable[2]) |=> (PAIR_LOW_OUTPUT[2] == $past(cfg_q.override_level[4]));
   endproperty
   a_pair3_forced: assert property (p_pair3_forced) else $error("pair three not forced");

   property p_latch_holds;
      @(posedge CLK) disable iff (!RSTN)
      (latched_q && !cfg_q.cycle_mode) |=> latched_q;
   endproperty
   a_latch_holds: assert property (p_latch_holds) else $error("latched fault dropped");

   property p_locked_write;
      @(posedge CLK) disable iff (!RSTN)
      (wr_access && hit_ctrl && lock_s && key_q != fault_a_pkg::KEY_OPEN
         && strap_cnt_q == 2'h3) |=> $stable(cfg_q);
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked write taken");

   property p_strap_reset;
      @(posedge CLK) disable iff (!RSTN)
      (strap_cnt_q == 2'h2 && !(wr_access && hit_ctrl))
         |=> (cfg_q.pair_enable == (lock_s ? 3'h7 : 3'h0)) || $changed(lock_s);
   endproperty
   a_strap_reset: assert property (p_strap_reset) else $error("enable reset wrong");

   property p_cbc_hold;
      @(posedge CLK) disable iff (!RSTN)
      (cfg_q.cycle_mode && cbc_q && !fault_active && !period_tick_w) |=> cbc_q;
   endproperty
   a_cbc_hold: assert property (p_cbc_hold) else $error("cycle override released early");

   property p_unimpl_zero;
      @(posedge CLK) disable iff (!RSTN)
      (setup && hit_ctrl) |=> (PRDATA[15:14] == 2'b00 && PRDATA[6:3] == 4'h0);
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits set");

   property p_ready_one_wait;
      @(posedge CLK) disable iff (!RSTN)
      setup |=> PREADY ##1 !PREADY;
   endproperty
   a_ready_one_wait: assert property (p_ready_one_wait) else $error("answer timing wrong");

   c_latched: cover property (@(posedge CLK) disable iff (!RSTN) $rose(latched_q));
   c_cbc_release: cover property (@(posedge CLK) disable iff (!RSTN) $fell(cbc_q));
   c_unlock: cover property (@(posedge CLK) disable iff (!RSTN) key_q == fault_a_pkg::KEY_OPEN);
endmodule
`default_nettype wire

// >>> fault_a_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ***************
// fault comparator and normal pwm levels
// ***************
module fault_a_partner (
   input wire logic trip,
   input wire logic [2:0] level_high,
   input wire logic [2:0] level_low,
   output logic fault_n,
   output logic [2:0] pwm_high,
   output logic [2:0] pwm_low
);
   // comparator output is active low, idle high
   assign fault_n = ~trip;
   // static generator levels so any forced pin shows against them
   assign pwm_high = level_high;
   assign pwm_low = level_low;
endmodule
`default_nettype wire

// >>> tb_fault_a_override.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_fault_a_override;
   // ***************
   // signals
   // ***************
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic fault_n;
   logic lock = 1'b0;
   logic trip = 1'b0;
   logic [2:0] lvl_h = 3'h0;
   logic [2:0] lvl_l = 3'h7;
   logic [2:0] pwm_h;
   logic [2:0] pwm_l;
   logic [2:0] out_h;
   logic [2:0] out_l;
   logic [31:0] rd;
   logic er;
   int mismatches = 0;
   int checks_done = 0;

   always #5 clk = ~clk;

   fault_a_override fault_a_override_inst (
      .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .FAULT_A_N(fault_n), .WRITE_LOCK_CONFIG(lock),
      .PWM_HIGH_IN(pwm_h), .PWM_LOW_IN(pwm_l),
      .PAIR_HIGH_OUTPUT(out_h), .PAIR_LOW_OUTPUT(out_l)
   );

   fault_a_partner fault_a_partner_inst (
      .trip(trip), .level_high(lvl_h), .level_low(lvl_l),
      .fault_n(fault_n), .pwm_high(pwm_h), .pwm_low(pwm_l)
   );

   // ***************
   // tasks
   // ***************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // values read right after the edge are the ones sampled on it
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      `CHK(pready, 1'b1)
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000);
      `CHK(rd, e)
   endtask

   task automatic pins(input logic [2:0] h, input logic [2:0] l);
      `CHK(out_h, h)
      `CHK(out_l, l)
   endtask

   task automatic rst(input logic l);
      rstn <= 1'b0;
      lock <= l;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask

   task results;
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ***************
   // tests
   // ***************
   initial
   begin
      rst(1'b0);
      rchk(fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00000000);
      apb(1'b1, fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'hFFFFFFFF);
      rchk(fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00003F87);
      apb(1'b1, 12'h010, 32'h00000000);
      `CHK(er, 1'b1)
      rchk(12'h010, 32'h00000000);
      // latched: pairs one and two forced, pair three left alone
      apb(1'b1, fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00002A03);
      trip <= 1'b1;
      repeat (8) @(posedge clk);
      pins(3'h3, 3'h4);
      trip <= 1'b0;
      repeat (8) @(posedge clk);
      pins(3'h3, 3'h4);
      rchk(fault_a_pkg::STATUS_OFFS, 32'h00000003);
      // long period so release after the fault is clearly deferred
      apb(1'b1, fault_a_pkg::PERIOD_OFFS, 32'h00000FFF);
      apb(1'b1, fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00002A84);
      trip <= 1'b1;
      repeat (8) @(posedge clk);
      pins(3'h4, 3'h3);
      trip <= 1'b0;
      repeat (8) @(posedge clk);
      pins(3'h4, 3'h3);
      repeat (4200) @(posedge clk);
      pins(3'h0, 3'h7);
      // strapped lock: enables set at reset, writes need the key
      rst(1'b1);
      rchk(fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00000007);
      apb(1'b1, fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00000000);
      rchk(fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00000007);
      apb(1'b1, fault_a_pkg::KEY_OFFS, {16'h0000, fault_a_pkg::KEY_FIRST});
      apb(1'b1, fault_a_pkg::KEY_OFFS, {16'h0000, fault_a_pkg::KEY_SECOND});
      apb(1'b1, fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00002A01);
      rchk(fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00002A01);
      apb(1'b1, fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00000000);
      rchk(fault_a_pkg::FAULT_A_CONTROL_OFFS, 32'h00002A01);
      results();
   end

   // bounded well past the expected run of some four thousand three hundred cycles
   initial
   begin
      #200000;
      `CHK(1'b0, 1'b1)
      results();
   end
endmodule
`default_nettype wire
